// ### src/four_colour_channels_light_sensor_readout.sv
`timescale 1ns/100ps
`include "four_colour_channels_regs.svh"
// Behaviour
// - four channels integrate together, each giving a result of up to 16 bits.
// - at cycle end each channel result is copied into its readable data register.
// - results are double-buffered so a read never mixes two cycles.
// - host reaches registers over a two-wire serial bus up to 400 kHz.
// - enabled threshold event asserts a level interrupt that holds until host clears.
// - result above upper or below lower threshold counts as out of range.
// - interrupt only after programmed consecutive out-of-range results; in-range restarts.
// - programmable wait timer between measurements, 2.4 ms to over seven seconds.
// - a state machine sequences measurements and idles in low power between them.
// - interrupt pin is open drain, pulled low when asserted, floating otherwise.
// - an integration step lasts 2.4 ms; setting 0xff gives one step.
// - integration steps programmable 1 to 256, each adding up to 1024 counts.
// - analog gain selectable among 1x, 4x, 16x and 60x.
module four_colour_channels_light_sensor_readout #(
    parameter int STEP_CYCLES = `STEP_CYCLES
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // analog front end
    input  wire four_colour_channels_pkg::step_counts_t stepCount,
    output logic                        integrating,
    output logic                        lowPower,
    output four_colour_channels_pkg::analog_gain_setting_t analogGain,
    // interrupt
    output logic                        irq,
    output logic                        intPinOut,
    output logic                        intPinOe
);

    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    // register state
    logic [2:0]                 enable_r;
    logic [7:0]                 integTime_r;
    logic [7:0]                 waitTime_r;
    logic [2:0]                 config_r;
    logic [15:0]                lowThr_r;
    logic [15:0]                highThr_r;
    logic [3:0]                 persist_r;
    logic [1:0]                 status_r;
    logic [1:0]                 mask_r;
    four_colour_channels_pkg::chan_results_t    data_r;
    logic [31:0]                prdata_r;
    logic                       slvErr_r;

    // sequencer state
    four_colour_channels_pkg::seq_state_t       state_r;
    four_colour_channels_pkg::seq_state_t       state_nxt;
    logic [STEP_W-1:0]          stepTimer_r;
    logic [8:0]                 stepsLeft_r;
    logic [3:0]                 longDiv_r;
    logic [3:0]                 oorCount_r;

    logic       stepTick;
    logic       lastStep;
    logic       waitStep;
    logic       lastWait;
    logic       outOfRange;
    logic       persistHit;
    logic [3:0] persistNeed;
    logic       wrEn;
    logic       setupPhase;
    logic [1:0] statusSet;
    logic [1:0] statusClr;

    conv_if conv ();

    channel_accum #(
        .CHANNELS (4)
    ) u_accum (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .conv    (conv.accum)
    );

    // address decode shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `OFS_STATE);
    endfunction : mapped

    // the serial-bus front end converts host transfers into apb accesses
    assign setupPhase = psel && !penable;
    assign wrEn       = psel && penable && pwrite && mapped(paddr);
    // zero wait states: every access completes in its first access cycle
    assign pready     = 1'b1;
    assign prdata     = prdata_r;
    assign pslverr    = slvErr_r;

    // configuration registers written by software
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_r    <= `RST_ENABLE;
            integTime_r <= `RST_INTEG;
            waitTime_r  <= `RST_WAIT;
            config_r    <= `RST_CONFIG;
            lowThr_r    <= `RST_LOW_THR;
            highThr_r   <= `RST_HIGH_THR;
            persist_r   <= `RST_PERSIST;
            mask_r      <= `RST_MASK;
        end
        else if (wrEn)
        begin
            case (paddr)
                `OFS_ENABLE:   enable_r    <= pwdata[2:0];
                `OFS_INTEG:    integTime_r <= pwdata[7:0];
                `OFS_WAIT:     waitTime_r  <= pwdata[7:0];
                `OFS_CONFIG:   config_r    <= pwdata[2:0];
                `OFS_LOW_THR:  lowThr_r    <= pwdata[15:0];
                `OFS_HIGH_THR: highThr_r   <= pwdata[15:0];
                `OFS_PERSIST:  persist_r   <= pwdata[3:0];
                `OFS_MASK:     mask_r      <= pwdata[1:0];
                default:       ;
            endcase
        end
    end

    // read data is prepared in the setup cycle so it comes straight from a flop
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            slvErr_r <= 1'b0;
        end
        else if (setupPhase)
        begin
            slvErr_r <= !mapped(paddr);
            case (paddr)
                `OFS_ENABLE:   prdata_r <= {29'h0, enable_r};
                `OFS_INTEG:    prdata_r <= {24'h0, integTime_r};
                `OFS_WAIT:     prdata_r <= {24'h0, waitTime_r};
                `OFS_CONFIG:   prdata_r <= {29'h0, config_r};
                `OFS_LOW_THR:  prdata_r <= {16'h0, lowThr_r};
                `OFS_HIGH_THR: prdata_r <= {16'h0, highThr_r};
                `OFS_PERSIST:  prdata_r <= {28'h0, persist_r};
                `OFS_STATUS:   prdata_r <= {30'h0, status_r};
                `OFS_MASK:     prdata_r <= {30'h0, mask_r};
                // only the second buffer is visible, never the running sum
                `OFS_RED:      prdata_r <= {16'h0, data_r[0]};
                `OFS_GREEN:    prdata_r <= {16'h0, data_r[1]};
                `OFS_BLUE:     prdata_r <= {16'h0, data_r[2]};
                `OFS_CLEAR:    prdata_r <= {16'h0, data_r[3]};
                `OFS_STATE:    prdata_r <= {26'h0, oorCount_r, state_r};
                default:       prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // step timer: one tick per 2.4 ms step in the integrate and wait states
    assign stepTick = (stepTimer_r == STEP_W'(STEP_CYCLES - 1));
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stepTimer_r <= '0;
        else if (state_r == four_colour_channels_pkg::SLEEP || state_r == four_colour_channels_pkg::CAPTURE || stepTick)
            stepTimer_r <= '0;
        else
            stepTimer_r <= stepTimer_r + STEP_W'(1);
    end

    // long wait stretches each wait step by twelve to pass seven seconds
    assign waitStep = stepTick && (!config_r[`CFG_LONG_WAIT]
                      || longDiv_r == 4'(`LONG_WAIT_MULT - 1));
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            longDiv_r <= 4'h0;
        else if (state_r != four_colour_channels_pkg::WAITING || waitStep)
            longDiv_r <= 4'h0;
        else if (stepTick)
            longDiv_r <= longDiv_r + 4'h1;
    end

    // step counts: setting 0xff gives one step, 0x00 gives 256
    assign lastStep = stepTick && (stepsLeft_r == 9'h001);
    assign lastWait = waitStep && (stepsLeft_r == 9'h001);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stepsLeft_r <= 9'h000;
        else if (state_nxt != state_r && state_nxt == four_colour_channels_pkg::INTEGRATE)
            stepsLeft_r <= 9'h100 - {1'b0, integTime_r};
        else if (state_nxt != state_r && state_nxt == four_colour_channels_pkg::WAITING)
            stepsLeft_r <= 9'h100 - {1'b0, waitTime_r};
        else if ((state_r == four_colour_channels_pkg::INTEGRATE && stepTick) || waitStep)
            stepsLeft_r <= stepsLeft_r - 9'h001;
    end

    // measurement sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            four_colour_channels_pkg::SLEEP:
                if (enable_r[`EN_POWER] && enable_r[`EN_MEASURE])
                    state_nxt = four_colour_channels_pkg::INTEGRATE;
            four_colour_channels_pkg::INTEGRATE:
                if (!enable_r[`EN_POWER] || !enable_r[`EN_MEASURE])
                    state_nxt = four_colour_channels_pkg::SLEEP;
                else if (lastStep)
                    state_nxt = four_colour_channels_pkg::CAPTURE;
            four_colour_channels_pkg::CAPTURE:
                if (!enable_r[`EN_POWER] || !enable_r[`EN_MEASURE])
                    state_nxt = four_colour_channels_pkg::SLEEP;
                else if (enable_r[`EN_WAIT])
                    state_nxt = four_colour_channels_pkg::WAITING;
                else
                    state_nxt = four_colour_channels_pkg::INTEGRATE;
            four_colour_channels_pkg::WAITING:
                if (!enable_r[`EN_POWER] || !enable_r[`EN_MEASURE])
                    state_nxt = four_colour_channels_pkg::SLEEP;
                else if (lastWait)
                    state_nxt = four_colour_channels_pkg::INTEGRATE;
            default:
                state_nxt = four_colour_channels_pkg::SLEEP;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= four_colour_channels_pkg::SLEEP;
        else
            state_r <= state_nxt;
    end

    // front end is powered only while integrating; sleep and wait draw little
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            integrating <= 1'b0;
            lowPower    <= 1'b1;
            analogGain  <= four_colour_channels_pkg::GAIN_X1;
        end
        else
        begin
            integrating <= (state_nxt == four_colour_channels_pkg::INTEGRATE);
            lowPower    <= (state_nxt != four_colour_channels_pkg::INTEGRATE);
            analogGain  <= four_colour_channels_pkg::analog_gain_setting_t'(
                           config_r[`CFG_GAIN_HI:`CFG_GAIN_LO]);
        end
    end

    // all four channels add their step count on the same tick
    assign conv.add    = (state_r == four_colour_channels_pkg::INTEGRATE) && stepTick;
    assign conv.counts = stepCount;
    // the running sum is dropped once captured or whenever idle
    assign conv.clear  = (state_r != four_colour_channels_pkg::INTEGRATE);

    // second buffer loads all channels at once at cycle end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            data_r <= '0;
        else if (state_r == four_colour_channels_pkg::CAPTURE)
            data_r <= conv.results;
    end

    // threshold check runs on the clear channel, the broadband reference
    assign outOfRange  = (conv.results[3] > highThr_r) || (conv.results[3] < lowThr_r);
    // a persistence setting of zero fires on every out-of-range result
    assign persistNeed = (persist_r == 4'h0) ? 4'h1 : persist_r;
    // one extra bit so a saturated count of 15 does not wrap back to zero
    assign persistHit  = outOfRange && (({1'b0, oorCount_r} + 5'h01) >= {1'b0, persistNeed});

    // consecutive out-of-range counter, restarted by any in-range result
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            oorCount_r <= 4'h0;
        else if (state_r == four_colour_channels_pkg::CAPTURE)
        begin
            if (!outOfRange)
                oorCount_r <= 4'h0;
            else if (oorCount_r != 4'hf)
                oorCount_r <= oorCount_r + 4'h1;
        end
    end

    // sticky status, write one to clear; a same-cycle event wins over the clear
    assign statusSet[`ST_CYCLE_DONE] = (state_r == four_colour_channels_pkg::CAPTURE);
    assign statusSet[`ST_THRESHOLD]  = (state_r == four_colour_channels_pkg::CAPTURE) && persistHit;
    assign statusClr = (wrEn && paddr == `OFS_STATUS) ? pwdata[1:0] : 2'b00;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            status_r <= 2'b00;
        else
            status_r <= (status_r & ~statusClr) | statusSet;
    end

    // level interrupt, held while any enabled status bit stays set
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |((status_r & ~statusClr | statusSet) & mask_r);
    end

    // open drain: drive low only when asserted, otherwise release the line
    assign intPinOut = 1'b0;
    assign intPinOe  = irq;

endmodule : four_colour_channels_light_sensor_readout

// ### src/four_colour_channels_regs.svh
`ifndef FOUR_COLOUR_CHANNELS_REGS_SVH
`define FOUR_COLOUR_CHANNELS_REGS_SVH

// register byte offsets
`define OFS_ENABLE     8'h00
`define OFS_INTEG      8'h04
`define OFS_WAIT       8'h08
`define OFS_CONFIG     8'h0c
`define OFS_LOW_THR    8'h10
`define OFS_HIGH_THR   8'h14
`define OFS_PERSIST    8'h18
`define OFS_STATUS     8'h1c
`define OFS_MASK       8'h20
`define OFS_RED        8'h24
`define OFS_GREEN      8'h28
`define OFS_BLUE       8'h2c
`define OFS_CLEAR      8'h30
`define OFS_STATE      8'h34

// enable register fields
`define EN_POWER       0
`define EN_MEASURE     1
`define EN_WAIT        2
// config register fields
`define CFG_GAIN_LO    0
`define CFG_GAIN_HI    1
`define CFG_LONG_WAIT  2
// status and mask fields
`define ST_CYCLE_DONE  0
`define ST_THRESHOLD   1

// reset values
`define RST_ENABLE     3'h0
`define RST_INTEG      8'hff
`define RST_WAIT       8'hff
`define RST_CONFIG     3'h0
`define RST_LOW_THR    16'h0000
`define RST_HIGH_THR   16'hffff
`define RST_PERSIST    4'h0
`define RST_MASK       2'h0

// timing
`define CLK_PERIOD_NS  50
`define STEP_TIME_NS   2400000
`define STEP_CYCLES    (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define LONG_WAIT_MULT 12
`define RESULT_MAX     16'hffff

`endif

// ### src/four_colour_channels_pkg.sv
package four_colour_channels_pkg;

    // measurement sequencer states
    typedef enum logic [1:0]
    {
        SLEEP,
        INTEGRATE,
        CAPTURE,
        WAITING
    } seq_state_t;

    // analog gain selections, relative to unity
    typedef enum logic [1:0]
    {
        GAIN_X1,
        GAIN_X4,
        GAIN_X16,
        GAIN_X60
    } analog_gain_setting_t;

    typedef logic [3:0][10:0] step_counts_t;
    typedef logic [3:0][15:0] chan_results_t;

endpackage : four_colour_channels_pkg

// ### src/conv_if.sv
`timescale 1ns/100ps
interface conv_if;
    logic                   clear;
    logic                   add;
    four_colour_channels_pkg::step_counts_t counts;
    four_colour_channels_pkg::chan_results_t results;

    modport ctrl  (output clear, output add, output counts, input results);
    modport accum (input clear, input add, input counts, output results);
endinterface : conv_if

// ### src/channel_accum.sv
`timescale 1ns/100ps
`include "four_colour_channels_regs.svh"
module channel_accum #(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // converter side
    conv_if.accum    conv
);

    // one saturating accumulator per channel, all stepping together
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            logic [16:0] sum;
            assign sum = {1'b0, conv.results[ch]} + {6'h00, conv.counts[ch]};
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    conv.results[ch] <= 16'h0000;
                else if (conv.clear)
                    conv.results[ch] <= 16'h0000;
                else if (conv.add)
                    // pin at full scale so a bright scene never reads dark
                    conv.results[ch] <= sum[16] ? `RESULT_MAX : sum[15:0];
            end
        end
    endgenerate

endmodule : channel_accum

// ### testbench/four_colour_channels_readout_monitor.sv
`timescale 1ns/100ps
`include "four_colour_channels_regs.svh"
module four_colour_channels_readout_monitor (
    // clock and reset
    input wire logic                           ref_clk,
    input wire logic                           rst_n,
    // apb slave
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [7:0]                     paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [31:0]                    prdata,
    input wire logic                           pslverr,
    // sequencer and interrupt
    input wire logic                           integrating,
    input wire logic                           lowPower,
    input wire four_colour_channels_pkg::analog_gain_setting_t analogGain,
    input wire logic                           irq,
    input wire logic                           intPinOut,
    input wire logic                           intPinOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // unaligned or past the last register
    logic badAdr;
    assign badAdr = (paddr > `OFS_STATE) || (paddr[1:0] != 2'h0);

    // refusals are reported from the access phase on, held until the next setup cycle
    property p_err; psel && !penable && badAdr |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_ok; psel && !penable && !badAdr |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("false slave error");
    property p_zero; psel && !penable && !pwrite && badAdr |=> prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("unmapped read not zero");
    // every value is at most 16 bits wide
    property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    // open drain: enable follows the level, driven value always low
    property p_oe; intPinOe == irq; endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from irq");
    property p_low; intPinOut == 1'b0; endproperty
    a_low: assert property (p_low) else $error("pin driven high");
    property p_pwr; lowPower != integrating; endproperty
    a_pwr: assert property (p_pwr) else $error("low power while integrating");
    property p_gain;
        psel && penable && pwrite && paddr == `OFS_CONFIG |-> ##2 analogGain == $past(pwdata[1:0], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain not applied");
    // the level only drops through a status clear, or a mask change one cycle later
    property p_irqfall;
        $fell(irq) |-> $past(psel && penable && pwrite && paddr == `OFS_STATUS)
            || $past(psel && penable && pwrite && paddr == `OFS_MASK, 2);
    endproperty
    a_irqfall: assert property (p_irqfall) else $error("irq dropped by itself");
endmodule : four_colour_channels_readout_monitor

bind four_colour_channels_light_sensor_readout four_colour_channels_readout_monitor u_mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .integrating(integrating), .lowPower(lowPower), .analogGain(analogGain),
    .irq(irq), .intPinOut(intPinOut), .intPinOe(intPinOe)
);

// ### testbench/light_front_end.sv
`timescale 1ns/100ps
module light_front_end (
    // clock
    input  wire logic                   ref_clk,
    // per-channel light levels, 0 to 1024
    input  wire four_colour_channels_pkg::step_counts_t level,
    // sequencer state
    input  wire logic                   integrating,
    // counts handed to the accumulators
    output four_colour_channels_pkg::step_counts_t      stepCount
);
    // outside integration the counts keep changing, so a stray sample shows up
    always_ff @(posedge ref_clk)
    begin
        if (integrating)
            stepCount <= level;
        else
            stepCount <= stepCount ^ {4{11'h3ff}};
    end
endmodule : light_front_end

// ### testbench/test_four_colour_channels_light_sensor_readout.sv
`timescale 1ns/100ps
`include "four_colour_channels_regs.svh"
module test_four_colour_channels_light_sensor_readout;
    localparam logic [7:0] RADR [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h1c, 8'h20, 8'h38, 8'h06};
    localparam logic [31:0] RVAL [11] = '{32'h0, 32'hff, 32'hff, 32'h0, 32'h0,
        32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [7:0] ITAB [4] = '{8'hff, 8'hfe, 8'hfd, 8'hc0};
    logic                           ref_clk = 1'b0;
    logic                           rst_n = 1'b0;
    logic                           psel = 1'b0;
    logic                           penable = 1'b0;
    logic                           pwrite = 1'b0;
    logic [7:0]                     paddr = 8'h00;
    logic [31:0]                    pwdata = 32'h0;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    four_colour_channels_pkg::step_counts_t         level = '0;
    four_colour_channels_pkg::step_counts_t         stepCount;
    logic                           integrating;
    logic                           lowPower;
    four_colour_channels_pkg::analog_gain_setting_t analogGain;
    logic                           irq;
    logic                           intPinOut;
    logic                           intPinOe;
    logic [31:0]                    rdat;
    logic                           rerr;
    int                             err_total = 0;
    int                             n_tests = 0;
    int                             seed = 32'h746d;

    always #25 ref_clk = ~ref_clk;

    // a short step keeps the long integrations affordable
    four_colour_channels_light_sensor_readout #(.STEP_CYCLES(20)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stepCount(stepCount), .integrating(integrating), .lowPower(lowPower),
        .analogGain(analogGain), .irq(irq), .intPinOut(intPinOut), .intPinOe(intPinOe)
    );
    light_front_end model (
        .ref_clk(ref_clk), .level(level), .integrating(integrating), .stepCount(stepCount)
    );

    function automatic logic [31:0] exp_res(input int n, input logic [10:0] l);
        int s;
        s = n * l;
        return (s > 65535) ? 32'hffff : 32'(s);
    endfunction : exp_res

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : check

    // one transfer; read data and error are taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // the watchdog bounds this wait
    task automatic wait_done();
        @(negedge integrating);
        repeat (2) @(posedge ref_clk);
    endtask : wait_done

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        check("low power", 32'(lowPower), 32'h1);
        for (int i = 0; i < 11; i++)
        begin
            apb(1'b0, RADR[i], 32'h0);
            check("reset value", rdat, RVAL[i]);
            check("slave error", 32'(rerr), 32'(i > 8));
        end
        $display("test reset done");
        for (int g = 0; g < 4; g++)
        begin
            apb(1'b1, `OFS_CONFIG, 32'(g));
            repeat (3) @(posedge ref_clk);
            check("gain", 32'(analogGain), 32'(g));
        end
        $display("test gain done");
        // random levels, one step up to a saturating 64 steps at full scale
        for (int k = 0; k < 4; k++)
        begin
            for (int c = 0; c < 4; c++)
                level[c] <= (k == 3) ? 11'h400 : 11'({$random(seed)} % 1025);
            apb(1'b1, `OFS_INTEG, {24'h0, ITAB[k]});
            apb(1'b1, `OFS_ENABLE, 32'h3);
            wait_done();
            apb(1'b1, `OFS_ENABLE, 32'h0);
            for (int c = 0; c < 4; c++)
            begin
                apb(1'b0, 8'(`OFS_RED + 4 * c), 32'h0);
                check("result", rdat, exp_res(256 - ITAB[k], level[c]));
            end
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("status", rdat, 32'h1);
            apb(1'b1, `OFS_STATUS, 32'h3);
        end
        $display("test results done");
        // clear channel 100 against an upper limit of 99, three in a row needed
        level[3] <= 11'h064;
        apb(1'b1, `OFS_INTEG, 32'hff);
        apb(1'b1, `OFS_HIGH_THR, 32'h63);
        apb(1'b1, `OFS_PERSIST, 32'h3);
        apb(1'b1, `OFS_MASK, 32'h2);
        apb(1'b1, `OFS_ENABLE, 32'h3);
        for (int i = 1; i < 4; i++)
        begin
            wait_done();
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("threshold", 32'(rdat[1]), 32'(i == 3));
            check("irq", 32'(irq), 32'(i == 3));
        end
        apb(1'b1, `OFS_ENABLE, 32'h0);
        apb(1'b1, `OFS_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("masked irq", 32'(irq), 32'h0);
        apb(1'b1, `OFS_MASK, 32'h2);
        repeat (2) @(posedge ref_clk);
        check("unmasked irq", 32'(intPinOe), 32'h1);
        apb(1'b1, `OFS_STATUS, 32'h2);
        repeat (2) @(posedge ref_clk);
        check("cleared irq", 32'(intPinOe), 32'h0);
        // below the lower limit counts too, every cycle with persistence 0
        apb(1'b1, `OFS_HIGH_THR, 32'hffff);
        apb(1'b1, `OFS_LOW_THR, 32'h65);
        apb(1'b1, `OFS_PERSIST, 32'h0);
        apb(1'b1, `OFS_ENABLE, 32'h3);
        wait_done();
        apb(1'b1, `OFS_ENABLE, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("below low", rdat & 32'h2, 32'h2);
        apb(1'b1, `OFS_STATUS, 32'h3);
        $display("test interrupt done");
        apb(1'b1, `OFS_WAIT, 32'hfe);
        apb(1'b1, `OFS_ENABLE, 32'h7);
        wait_done();
        apb(1'b0, `OFS_STATE, 32'h0);
        check("wait state", rdat & 32'h3, 32'h3);
        check("wait power", 32'(lowPower), 32'h1);
        apb(1'b1, `OFS_ENABLE, 32'h0);
        apb(1'b0, `OFS_STATE, 32'h0);
        check("sleep state", rdat & 32'h3, 32'h0);
        $display("test wait done");
        finish_test();
    end

    // the whole sequence needs well under ten thousand cycles
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
endmodule : test_four_colour_channels_light_sensor_readout
